/* File: src/rsc_defines.vh */
// Constants for the regulator start-up and ramp control block
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RSC_REG_PART_IDENTIFICATION   8'h04
`define RSC_REG_TCODE_HI  8'h12
`define RSC_REG_TCODE_LO  8'h13
`define RSC_REG_RAMP_CTL  8'h14
`define RSC_REG_BUS_CFG   8'h1a
`define RSC_REG_RDN_ARM   8'h1c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSC_BIT_TCODE_MSB 0
`define RSC_BIT_RDN_REQ   2
`define RSC_BIT_RATE      3
`define RSC_BIT_BUS_LEVEL 1
`define RSC_BIT_RDN_ARM   3
// ----------------------------------------
// Reset and factory values
// ----------------------------------------
`define RSC_RST_REG       8'h00
`define RSC_RST_RAMP_CTL  8'h01
`define RSC_BASE_ADDR     8'h08
`define RSC_TCODE_DFLT    9'h0fa
`define RSC_OFFSET_MV     13'h0320
// ----------------------------------------
// Timing
// ----------------------------------------
`define RSC_CLK_NS        10
`define RSC_INIT_NS       20000
`define RSC_STEP_SLOW_NS  1000
`define RSC_STEP_FAST_NS  500
`endif

/* File: src/rsc_i2c_slave.v */
// I2C target: byte shifting, address match, register pointer and data strobes
module rsc_i2c_slave (
  // Clock and reset
  input  wire       clock_in,
  input  wire       rstn_in,
  // Control
  input  wire       en_in,
  input  wire [6:0] addr_in,
  // Bus pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_oe_out,
  // Register side
  output reg  [7:0] ptr_out,
  output reg        wr_stb_out,
  output reg  [7:0] wr_data_out,
  input  wire [7:0] rd_data_in
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam IDLE  = 3'd0;
  localparam ADDR  = 3'd1;
  localparam ACK_A = 3'd2;
  localparam WR    = 3'd3;
  localparam ACK_W = 3'd4;
  localparam RD    = 3'd5;
  localparam ACK_R = 3'd6;

  reg [2:0] scl_q;  // Sync stages and previous value
  reg [2:0] sda_q;  // Sync stages and previous value
  reg [2:0] st_q;   // Protocol state
  reg [3:0] cnt_q;  // Bits seen in the byte
  reg [7:0] sh_q;   // Shift register
  reg       rw_q;   // Read direction
  reg       first_q;// Next written byte is the pointer
  reg       nack_q; // Master refused the last read byte

  // Edges are taken from the second stage onward only
  wire rise  = scl_q[1] & ~scl_q[2];
  wire fall  = ~scl_q[1] & scl_q[2];
  wire start = scl_q[1] & sda_q[2] & ~sda_q[1];
  wire stop  = scl_q[1] & ~sda_q[2] & sda_q[1];

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_out <= 1'b0;
      ptr_out <= 8'h00;
      wr_stb_out <= 1'b0;
      wr_data_out <= 8'h00;
    end else begin
      wr_stb_out <= 1'b0;
      // Bus is ignored until initialisation ends
      if (!en_in || stop) begin
        st_q <= IDLE;
        sda_oe_out <= 1'b0;
      end else if (start) begin
        // Start or repeated start
        st_q <= ADDR;
        cnt_q <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (rise) begin
        if (st_q == ACK_R) begin
          nack_q <= sda_q[1];
        end else begin
          if (st_q != RD) begin
            sh_q <= {sh_q[6:0], sda_q[1]};
          end
          cnt_q <= cnt_q + 4'h1;
        end
      end else if (fall) begin
        case (st_q)
          ADDR: begin
            if (cnt_q == 4'h8) begin
              if (sh_q[7:1] == addr_in) begin
                sda_oe_out <= 1'b1;
                rw_q <= sh_q[0];
                st_q <= ACK_A;
              end else begin
                st_q <= IDLE;
              end
            end
          end
          ACK_A: begin
            cnt_q <= 4'h0;
            first_q <= 1'b1;
            if (rw_q) begin
              // Read returns the pointed register
              sh_q <= rd_data_in;
              sda_oe_out <= ~rd_data_in[7];
              st_q <= RD;
            end else begin
              sda_oe_out <= 1'b0;
              st_q <= WR;
            end
          end
          WR: begin
            if (cnt_q == 4'h8) begin
              sda_oe_out <= 1'b1;
              st_q <= ACK_W;
              // First byte is the pointer, then data
              if (first_q) begin
                ptr_out <= sh_q;
              end else begin
                wr_stb_out <= 1'b1;
                wr_data_out <= sh_q;
              end
            end
          end
          ACK_W: begin
            sda_oe_out <= 1'b0;
            cnt_q <= 4'h0;
            st_q <= WR;
            first_q <= 1'b0;
            if (!first_q) begin
              ptr_out <= ptr_out + 8'h01;
            end
          end
          RD: begin
            if (cnt_q == 4'h8) begin
              sda_oe_out <= 1'b0;
              ptr_out <= ptr_out + 8'h01;
              st_q <= ACK_R;
            end else begin
              sda_oe_out <= ~sh_q[3'd7 - cnt_q[2:0]];
            end
          end
          ACK_R: begin
            cnt_q <= 4'h0;
            if (nack_q) begin
              st_q <= IDLE;
            end else begin
              sh_q <= rd_data_in;
              sda_oe_out <= ~rd_data_in[7];
              st_q <= RD;
            end
          end
          default: st_q <= IDLE;
        endcase
      end
    end
  end
endmodule // rsc_i2c_slave

/* File: src/rsc_ramp_ctrl.v */
// Start-up sequencing, registers, soft-start ramp and drive gating of a buck regulator
// How it works
// - Bus answers only once initialisation is done
// - Register 0x04 returns fixed part code
// - 0x1A bit 1 picks bus level
// - Stored base address defaults to 0x08
// - Strap offset 0 to 3 added
// - Lockout release loads memory, reads strap
// - Ramp starts after init and run
// - 0x14 bit 3 picks ramp rate
// - Nine-bit target from 0x12/0x13
// - Target is 0.8V plus code times 10mV
// - Faults stay active during ramp
// - Switches off until ramp exceeds output
// - Output ok waits for first pulse
// - Run low kills drivers and reference
// - Armed request ramps down, then off
// - Request 0x14 bit 2, arm 0x1C bit 3
// - Minimum pulses, on-time grows with output
`include "rsc_defines.vh"
module rsc_ramp_ctrl #(
  parameter [7:0] PART_IDENTIFICATION  = 8'h5a,  // Arbitrary value
  parameter       PERIOD   = 90,     // Switching period in cycles
  parameter       MIN_ON   = 4,      // Minimum high-side on-time
  parameter       INIT_CYC = `RSC_INIT_NS / `RSC_CLK_NS
) (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rstn_in,
  // Supervisory pins
  input  wire        bias_ok_in,
  input  wire        run_in,
  input  wire [1:0]  strap_code_in,
  input  wire        ocp_fault_in,
  input  wire        ovp_fault_in,
  // Serial bus
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_out,
  // Output sense, same clock
  input  wire [12:0] vsense_mv_in,
  // Drive and status
  output reg         high_side_pulse_out,
  output reg         low_side_on_out,
  output reg  [12:0] ref_mv_out,
  output wire        output_ok_flag_out,
  output wire        output_ok_flag_oe_out,
  output wire        bus_level_out,
  output wire        ready_out
);
  // ----------------------------------------
  // Constants
  // ----------------------------------------
  // Clocks between one-millivolt reference steps, per rate
  localparam integer STEP_SLOW = `RSC_STEP_SLOW_NS / `RSC_CLK_NS;
  localparam integer STEP_FAST = `RSC_STEP_FAST_NS / `RSC_CLK_NS;

  // Init states
  localparam I_LOCK  = 2'd0;
  localparam I_LOAD  = 2'd1;
  localparam I_STRAP = 2'd2;
  localparam I_READY = 2'd3;

  // Ramp states
  localparam R_OFF  = 2'd0;
  localparam R_UP   = 2'd1;
  localparam R_ON   = 2'd2;
  localparam R_DOWN = 2'd3;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [5:0] sy1_q;  // First stage
  reg [5:0] sy2_q;  // Second stage

  // Every supervisory pin passes two flops before any logic reads it
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sy1_q <= 6'h00;
      sy2_q <= 6'h00;
    end else begin
      sy1_q <= {bias_ok_in, run_in, strap_code_in, ocp_fault_in, ovp_fault_in};
      sy2_q <= sy1_q;
    end
  end

  // Synchronised pin levels
  wire bias_ok = sy2_q[5];
  wire run     = sy2_q[4];
  wire fault   = sy2_q[1] | sy2_q[0];

  // ----------------------------------------
  // Initialisation sequencer
  // ----------------------------------------
  reg [1:0]  ist_q;      // Init state
  reg [15:0] icnt_q;     // Memory load timer
  reg [7:0]  base_q;     // Stored base address
  reg [1:0]  strap_q;    // Captured address offset
  reg        load_stb_q; // Copy factory image this cycle

  // Lockout, memory load, strap capture, then ready
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ist_q <= I_LOCK;
      icnt_q <= 16'h0000;
      base_q <= 8'h00;
      strap_q <= 2'h0;
      load_stb_q <= 1'b0;
    end else begin
      load_stb_q <= 1'b0;
      if (!bias_ok) begin
        // Back to reset whenever the bias supply drops
        ist_q <= I_LOCK;
      end else begin
        case (ist_q)
          I_LOCK: begin
            // Lockout released, start loading
            icnt_q <= 16'h0000;
            ist_q <= I_LOAD;
          end
          I_LOAD: begin
            if (icnt_q == INIT_CYC[15:0] - 16'h0001) begin
              base_q <= `RSC_BASE_ADDR;
              load_stb_q <= 1'b1;
              ist_q <= I_STRAP;
            end else begin
              icnt_q <= icnt_q + 16'h0001;
            end
          end
          I_STRAP: begin
            // Offset code from the address detector
            strap_q <= sy2_q[3:2];
            ist_q <= I_READY;
          end
          default: ist_q <= I_READY;
        endcase
      end
    end
  end

  // Bus answers and ramp may start from here on
  assign ready_out = (ist_q == I_READY);
  // Target address is base plus strap offset
  wire [7:0] bus_addr = base_q + {6'h00, strap_q};

  // ----------------------------------------
  // Serial target
  // ----------------------------------------
  // Pointer, write strobe and read data of the target
  wire [7:0] ptr;
  wire       wr_stb;
  wire [7:0] wr_data;
  reg  [7:0] rd_data;

  // Target is held idle until initialisation ends
  rsc_i2c_slave u_i2c (
    .clock_in    (clock_in),
    .rstn_in     (rstn_in),
    .en_in       (ready_out),
    .addr_in     (bus_addr[6:0]),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .sda_oe_out  (sda_oe_out),
    .ptr_out     (ptr),
    .wr_stb_out  (wr_stb),
    .wr_data_out (wr_data),
    .rd_data_in  (rd_data)
  );
  assign sda_out = 1'b0;  // Open drain, only pulls low

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg [7:0] thi_q;  // Target code upper
  reg [7:0] tlo_q;  // Target code lower
  reg [7:0] rct_q;  // Ramp control
  reg [7:0] bus_q;  // Bus level config
  reg [7:0] arm_q;  // Ramp-down arming

  wire [8:0] tcode_dflt = `RSC_TCODE_DFLT;  // Factory target code

  // Factory load has priority over a bus write in the same cycle
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      thi_q <= `RSC_RST_REG;
      tlo_q <= `RSC_RST_REG;
      rct_q <= `RSC_RST_RAMP_CTL;
      bus_q <= `RSC_RST_REG;
      arm_q <= `RSC_RST_REG;
    end else if (load_stb_q) begin
      // Memory image into working registers
      thi_q <= {7'h00, tcode_dflt[8]};
      tlo_q <= tcode_dflt[7:0];
    end else if (wr_stb) begin
      case (ptr)
        `RSC_REG_TCODE_HI: thi_q <= wr_data;
        `RSC_REG_TCODE_LO: tlo_q <= wr_data;
        `RSC_REG_RAMP_CTL: rct_q <= wr_data;
        `RSC_REG_BUS_CFG:  bus_q <= wr_data;
        `RSC_REG_RDN_ARM:  arm_q <= wr_data;
        default: ;
      endcase
    end
  end

  // Read mux, unmapped reads return zero
  always @* begin
    case (ptr)
      `RSC_REG_PART_IDENTIFICATION:  rd_data = PART_IDENTIFICATION;
      `RSC_REG_TCODE_HI: rd_data = thi_q;
      `RSC_REG_TCODE_LO: rd_data = tlo_q;
      `RSC_REG_RAMP_CTL: rd_data = rct_q;
      `RSC_REG_BUS_CFG:  rd_data = bus_q;
      `RSC_REG_RDN_ARM:  rd_data = arm_q;
      default:           rd_data = 8'h00;
    endcase
  end

  // Register fields
  assign bus_level_out = bus_q[`RSC_BIT_BUS_LEVEL];
  wire       fast   = rct_q[`RSC_BIT_RATE];
  wire       rdn    = rct_q[`RSC_BIT_RDN_REQ] & arm_q[`RSC_BIT_RDN_ARM];
  wire [8:0] tcode  = {thi_q[`RSC_BIT_TCODE_MSB], tlo_q};
  // Offset plus code times ten millivolts
  wire [12:0] tgt_mv = `RSC_OFFSET_MV + {1'b0, tcode, 3'h0} + {3'h0, tcode, 1'b0};

  // ----------------------------------------
  // Reference ramp
  // ----------------------------------------
  reg [1:0] rst_q;   // Ramp state
  reg [6:0] scnt_q;  // Step timer
  wire [6:0] step_len = fast ? STEP_FAST[6:0] : STEP_SLOW[6:0];
  wire       step     = (scnt_q == step_len - 7'h01);

  // One millivolt per step toward the target, or down to zero
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_q <= R_OFF;
      scnt_q <= 7'h00;
      ref_mv_out <= 13'h0000;
    end else if (!run || !ready_out || fault) begin
      // Hard stop or fault: reference to zero now
      rst_q <= R_OFF;
      scnt_q <= 7'h00;
      ref_mv_out <= 13'h0000;
    end else begin
      scnt_q <= step ? 7'h00 : scnt_q + 7'h01;
      case (rst_q)
        R_OFF: begin
          // Start once ready and run, unless held stopped
          scnt_q <= 7'h00;
          if (!rdn) begin
            rst_q <= R_UP;
          end
        end
        R_UP, R_ON: begin
          if (rdn) begin
            rst_q <= R_DOWN;
          end else if (step && ref_mv_out < tgt_mv) begin
            ref_mv_out <= ref_mv_out + 13'h0001;
            rst_q <= R_UP;
          end else if (step && ref_mv_out > tgt_mv) begin
            ref_mv_out <= ref_mv_out - 13'h0001;
          end else if (ref_mv_out == tgt_mv) begin
            rst_q <= R_ON;
          end
        end
        R_DOWN: begin
          // Same rate down; drivers off at zero
          if (!rdn) begin
            rst_q <= R_UP;
          end else if (ref_mv_out == 13'h0000) begin
            rst_q <= R_OFF;
          end else if (step) begin
            ref_mv_out <= ref_mv_out - 13'h0001;
          end
        end
        default: rst_q <= R_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // Drive gating and on-time control
  // ----------------------------------------
  reg [7:0] pcnt_q;   // Position in switching period
  reg [7:0] ton_q;    // High-side on-time
  reg       go_q;     // Pre-bias gate opened
  reg       first_q;  // First high-side pulse issued
  // Gates may only run while the ramp is live and no fault stands
  wire act = (rst_q != R_OFF) && !fault && run;

  // Period counter, on-time and gate outputs
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pcnt_q <= 8'h00;
      ton_q <= MIN_ON[7:0];
      go_q <= 1'b0;
      first_q <= 1'b0;
      high_side_pulse_out <= 1'b0;
      low_side_on_out <= 1'b0;
    end else if (!act) begin
      // Both switches off
      pcnt_q <= 8'h00;
      ton_q <= MIN_ON[7:0];
      go_q <= 1'b0;
      first_q <= 1'b0;
      high_side_pulse_out <= 1'b0;
      low_side_on_out <= 1'b0;
    end else begin
      // Hold off until reference passes the output
      if (ref_mv_out > vsense_mv_in) begin
        go_q <= 1'b1;
      end
      pcnt_q <= (pcnt_q == PERIOD[7:0] - 8'h01) ? 8'h00 : pcnt_q + 8'h01;
      if (pcnt_q == 8'h00) begin
        // Grow on-time while output is below reference
        if (vsense_mv_in < ref_mv_out && ton_q < PERIOD[7:0] - 8'h02) begin
          ton_q <= ton_q + 8'h01;
        end else if (vsense_mv_in > ref_mv_out && ton_q > MIN_ON[7:0]) begin
          ton_q <= ton_q - 8'h01;
        end
      end
      // High side first, then complementary low side
      high_side_pulse_out <= go_q && (pcnt_q < ton_q);
      low_side_on_out <= go_q && first_q && (pcnt_q >= ton_q);
      if (go_q && pcnt_q < ton_q) begin
        first_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Output ok, open drain pulling low when not ok
  // ----------------------------------------
  // Flag stays low until first pulse and target reached
  wire ok = first_q && (rst_q == R_ON);
  assign output_ok_flag_out = 1'b0;
  assign output_ok_flag_oe_out = ~ok;

endmodule // rsc_ramp_ctrl

/* File: tb/rsc_i2c_master.sv */
// Bus master model framing register transfers on the two-wire bus
module rsc_i2c_master (
  // Bus pins
  output logic scl_out,
  output logic sda_low_out,  // High pulls the data line low
  input  logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus: both lines released
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // One 80 ns bit slot, long low phase so the target's release lands first
  task automatic bit_io(input logic b, output logic r);
    #40 sda_low_out = !b;
    #16 scl_out = 1'b1;
    #22 r = sda_in;
    #2 scl_out = 1'b0;
  endtask
  // Start or repeated start
  task automatic start_c;
    #40 sda_low_out = 1'b0;
    #16 scl_out = 1'b1;
    #20 sda_low_out = 1'b1;
    #20 scl_out = 1'b0;
  endtask
  // Stop, then bus free time
  task automatic stop_c;
    #40 sda_low_out = 1'b1;
    #16 scl_out = 1'b1;
    #20 sda_low_out = 1'b0;
    #80;
  endtask
  // Eight bits out, then the acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, r);
    ack = (r === 1'b0);
  endtask
  // Pointer then data byte
  task automatic wr(input logic [6:0] a, input logic [7:0] p, d, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start_c;
    byte_io({a, 1'b0}, 1'b1, q, a0);
    byte_io(p, 1'b1, q, a1);
    byte_io(d, 1'b1, q, a2);
    stop_c;
    ok = a0 & a1 & a2;
  endtask
  // Pointer, repeated start, one byte read and refused
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic a0, a1, a2, n;
    start_c;
    byte_io({a, 1'b0}, 1'b1, d, a0);
    byte_io(p, 1'b1, d, a1);
    start_c;
    byte_io({a, 1'b1}, 1'b1, d, a2);
    byte_io(8'hff, 1'b1, d, n);
    stop_c;
    ok = a0 & a1 & a2;
  endtask
endmodule // rsc_i2c_master

/* File: tb/rsc_ramp_ctrl_bench.sv */
// Self-checking bench for the start-up and ramp control block
module rsc_ramp_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [7:0] PART = 8'h3c;  // Arbitrary part code
  localparam [6:0] DEV  = 7'h0a;  // Base 0x08 plus strap 2
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock_in, rstn_in, bias_ok_in, run_in, ocp_fault_in, ovp_fault_in;
  logic [1:0]  strap_code_in;
  logic [12:0] vsense_mv_in, ref_mv_out;
  logic scl, mst_low, sda_oe_out, high_side_pulse_out, low_side_on_out;
  logic output_ok_flag_oe_out, bus_level_out, ready_out, ack;
  logic [7:0] d;
  wire  sda = !(mst_low | sda_oe_out);  // Pulled-up open-drain line
  int   error_cnt = 0;
  int   n_tests = 0;
  int   k;
  // Rows: pointer, value before write, value written, value read back
  logic [31:0] rows [8] = '{{8'h12, 8'h00, 8'h01, 8'h01}, {8'h13, 8'hfa, 8'h01, 8'h01},
    {8'h12, 8'h01, 8'h00, 8'h00}, {8'h14, 8'h01, 8'h09, 8'h09}, {8'h1a, 8'h00, 8'h02, 8'h02},
    {8'h1c, 8'h00, 8'h08, 8'h08}, {8'h04, PART, 8'hff, PART}, {8'h30, 8'h00, 8'h55, 8'h00}};
  rsc_ramp_ctrl #(.PART_IDENTIFICATION(PART), .INIT_CYC(5)) dut (
    .clock_in(clock_in), .rstn_in(rstn_in), .bias_ok_in(bias_ok_in), .run_in(run_in),
    .strap_code_in(strap_code_in), .ocp_fault_in(ocp_fault_in), .ovp_fault_in(ovp_fault_in),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe_out), .vsense_mv_in(vsense_mv_in),
    .high_side_pulse_out(high_side_pulse_out), .low_side_on_out(low_side_on_out), .ref_mv_out(ref_mv_out),
    .output_ok_flag_out(), .output_ok_flag_oe_out(output_ok_flag_oe_out), .bus_level_out(bus_level_out),
    .ready_out(ready_out));
  rsc_i2c_master u_mst (.scl_out(scl), .sda_low_out(mst_low), .sda_in(sda));
  // ----------------------------------------
  // Clock, compare, verdict, watchdog
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = !clock_in;
  end
  task automatic check(input logic [12:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("Mismatches %0d of %0d compares", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (70000) @(posedge clock_in);
    error_cnt++;
    stop_test;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rstn_in, bias_ok_in, run_in, ocp_fault_in, ovp_fault_in} = 5'b00000;
    strap_code_in = 2'd2;
    vsense_mv_in = 13'd0;
    repeat (20) @(negedge clock_in);
    check({ready_out, output_ok_flag_oe_out, sda_oe_out}, 3'b010);
    rstn_in = 1'b1;
    u_mst.wr(DEV, 8'h12, 8'h01, ack);
    check(ack, 1'b0);
    @(negedge clock_in);
    bias_ok_in = 1'b1;
    for (k = 0; k < 50 && ready_out !== 1'b1; k++) @(negedge clock_in);
    check(ready_out, 1'b1);
    u_mst.wr(7'h08, 8'h13, 8'h11, ack);
    check(ack, 1'b0);
    foreach (rows[i]) begin
      u_mst.rd(DEV, rows[i][31:24], d, ack);
      check(d, rows[i][23:16]);
      u_mst.wr(DEV, rows[i][31:24], rows[i][15:8], ack);
      check(ack, 1'b1);
      u_mst.rd(DEV, rows[i][31:24], d, ack);
      check(d, rows[i][7:0]);
    end
    check(bus_level_out, 1'b1);
    @(negedge clock_in);
    vsense_mv_in = 13'd20;
    run_in = 1'b1;
    // Pre-charged start, then stop by run pin, over-voltage and over-current
    for (int j = 0; j < 4; j++) begin
      for (k = 0; k < 3000 && high_side_pulse_out !== 1'b1; k++) begin
        check(output_ok_flag_oe_out, 1'b1);
        @(negedge clock_in);
      end
      check(ref_mv_out > 13'd20, 1'b1);
      if (j == 3) break;
      run_in = (j != 0);
      ovp_fault_in = (j == 1);
      ocp_fault_in = (j == 2);
      repeat (4) @(negedge clock_in);
      check(ref_mv_out + high_side_pulse_out + low_side_on_out, 13'd0);
      {run_in, ovp_fault_in, ocp_fault_in} = 3'b100;
    end
    // Soft stop low in the ramp, then release it and ramp to the target
    u_mst.wr(DEV, 8'h14, 8'h0d, ack);
    check(ref_mv_out != 13'd0, 1'b1);
    for (k = 0; k < 3000 && ref_mv_out !== 13'd0; k++) @(negedge clock_in);
    check(ref_mv_out, 13'd0);
    repeat (3) @(negedge clock_in);
    check(high_side_pulse_out + low_side_on_out, 13'd0);
    u_mst.wr(DEV, 8'h14, 8'h09, ack);
    for (k = 0; k < 45000 && ref_mv_out !== 13'd810; k++) @(negedge clock_in);
    check(ref_mv_out, 13'd810);
    repeat (5) @(negedge clock_in);
    check(output_ok_flag_oe_out, 1'b0);
    stop_test;
  end
endmodule // rsc_ramp_ctrl_bench

/* File: tb/rsc_ramp_ctrl_monitor.sv */
// Concurrent checks on the ports of the start-up and ramp control block
module rsc_ramp_ctrl_monitor #(
  parameter INIT_CYC = 5  // Memory load time in cycles
) (
  // Clock and reset
  input logic        clock_in,
  input logic        rstn_in,
  // Supervisory and sense inputs
  input logic        bias_ok_in,
  input logic        run_in,
  input logic        ocp_fault_in,
  input logic        ovp_fault_in,
  input logic [12:0] vsense_mv_in,
  // Outputs watched
  input logic        sda_oe_out,
  input logic        high_side_pulse_out,
  input logic        low_side_on_out,
  input logic [12:0] ref_mv_out,
  input logic        output_ok_flag_oe_out,
  input logic        ready_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [15:0] bias_cnt_q;  // Cycles with bias held high
  logic [7:0]  gap_q;       // Cycles since the reference last moved
  logic [12:0] prev_q;      // Reference one cycle back
  logic        seen_q;      // High-side pulse seen since reference left zero
  wire         drv = high_side_pulse_out | low_side_on_out;
  // Track bias time, step spacing and first pulse
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bias_cnt_q <= 16'h0000;
      gap_q      <= 8'h00;
      prev_q     <= 13'h0000;
      seen_q     <= 1'b0;
    end else begin
      bias_cnt_q <= bias_ok_in ? bias_cnt_q + 16'h0001 : 16'h0000;
      gap_q      <= (ref_mv_out != prev_q) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
      prev_q     <= ref_mv_out;
      seen_q     <= (ref_mv_out == 13'h0000) ? 1'b0 : (seen_q | high_side_pulse_out);
    end
  end
  // ----------------------------------------
  // Sequences and assertions
  // ----------------------------------------
  sequence s_run_lost;
    !run_in [*4];
  endsequence
  sequence s_fault;
    (ocp_fault_in || ovp_fault_in) [*4];
  endsequence
  sequence s_ref_moves;
    $changed(ref_mv_out) && ref_mv_out != 0 && $past(ref_mv_out) != 0;
  endsequence
  AST_NO_ACK_IN_INIT: assert property (!ready_out && $past(!ready_out) |-> !sda_oe_out)
    else $error("bus answered before ready");
  AST_READY_AFTER_LOAD: assert property ($rose(ready_out) |-> bias_cnt_q >= INIT_CYC + 2)
    else $error("ready rose too early");
  AST_IDLE_UNTIL_READY: assert property (!ready_out && $past(!ready_out) && $past(!ready_out, 2) |->
    !drv && ref_mv_out == 0 && output_ok_flag_oe_out)
    else $error("activity before ready");
  AST_HARD_STOP: assert property (s_run_lost |-> ref_mv_out == 0 && !drv)
    else $error("run low did not stop");
  AST_FAULT_OFF: assert property (s_fault |-> ref_mv_out == 0 && !drv)
    else $error("fault did not stop");
  AST_REF_STEP: assert property (s_ref_moves |-> gap_q >= 49 &&
    (ref_mv_out == $past(ref_mv_out) + 1 || ref_mv_out + 1 == $past(ref_mv_out)))
    else $error("reference step wrong");
  AST_OFF_AT_ZERO: assert property (ref_mv_out == 0 && $past(ref_mv_out) == 0 &&
    $past(ref_mv_out, 2) == 0 |-> !drv)
    else $error("drivers on at zero reference");
  AST_LOW_AFTER_HIGH: assert property ($rose(low_side_on_out) |-> $past(high_side_pulse_out))
    else $error("low side without high pulse");
  AST_PULSE_ABOVE_OUT: assert property ($rose(high_side_pulse_out) && !seen_q |->
    $past(ref_mv_out) > $past(vsense_mv_in))
    else $error("first pulse below output");
  AST_OK_NEEDS_PULSE: assert property (!output_ok_flag_oe_out |-> seen_q)
    else $error("output ok before pulse");
endmodule // rsc_ramp_ctrl_monitor

bind rsc_ramp_ctrl rsc_ramp_ctrl_monitor #(.INIT_CYC(INIT_CYC)) u_mon (
  .clock_in(clock_in), .rstn_in(rstn_in), .bias_ok_in(bias_ok_in), .run_in(run_in),
  .ocp_fault_in(ocp_fault_in), .ovp_fault_in(ovp_fault_in), .vsense_mv_in(vsense_mv_in),
  .sda_oe_out(sda_oe_out), .high_side_pulse_out(high_side_pulse_out), .low_side_on_out(low_side_on_out),
  .ref_mv_out(ref_mv_out), .output_ok_flag_oe_out(output_ok_flag_oe_out), .ready_out(ready_out));
